//--- hdl/dual_output_pwm_timer.sv
// Purpose: dual-edge pwm timer with one counter and two driven output pins
// Assumes: all inputs synchronous to clk_sys; counter steps once per rising clk_sys edge while running
// Notes:   pin levels follow the counter with one cycle of register delay
`timescale 1ns/1ns

module dual_output_pwm_timer (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         reset,
  // counter control
  input  wire logic                         count_run_bit,
  input  wire logic                         match_continue_select,
  input  wire logic [pwm_pkg::NUM_CMP-1:0]  buffer_enable,
  // compare and buffer writes
  input  wire logic                         wr_en,
  input  wire pwm_pkg::reg_sel_t            wr_sel,
  input  wire pwm_pkg::count_t              wr_data,
  // output configuration
  input  wire logic                         pin_enable_a,
  input  wire logic                         pin_enable_b,
  input  wire logic                         active_high_a,
  input  wire logic                         active_high_b,
  input  wire logic                         cutoff_enable,
  input  wire logic                         cutoff_in,
  // interrupt
  input  wire logic                         irq_enable,
  input  wire logic                         flag_clear,
  output logic                              period_match_flag,
  output logic                              period_irq,
  // status
  output pwm_pkg::count_t                   count_register,
  // driven pins
  output logic                              pwm_out_a,
  output logic                              pwm_out_a_oe_n,
  output logic                              pwm_out_b,
  output logic                              pwm_out_b_oe_n,
  // pins kept disabled in this mode
  output logic                              unused_out_c0,
  output logic                              unused_out_c0_oe_n,
  output logic                              unused_out_d0,
  output logic                              unused_out_d0_oe_n,
  output logic                              unused_out_a1,
  output logic                              unused_out_a1_oe_n,
  output logic                              unused_out_b1,
  output logic                              unused_out_b1_oe_n,
  output logic                              unused_out_c1,
  output logic                              unused_out_c1_oe_n,
  output logic                              unused_out_d1,
  output logic                              unused_out_d1_oe_n
);

  // =====================================================================
  // state
  // =====================================================================
  typedef struct packed {
    pwm_pkg::count_t count;
    logic            halted;
    logic            started;
    logic            act_a;
    logic            act_b;
    logic            pin_a;
    logic            pin_b;
    logic            oe_a_n;
    logic            oe_b_n;
    logic            flag;
  } timer_s;

  timer_s st_q;
  timer_s st_d;

  // =====================================================================
  // compare bank
  // =====================================================================
  cmp_if cif ();

  pwm_pkg::count_t period_cmp;
  pwm_pkg::count_t a_set_cmp;
  pwm_pkg::count_t b_clear_cmp;
  pwm_pkg::count_t b_set_cmp;
  logic            running;
  logic            period_match;
  logic            cut;

  assign cif.wr_en        = wr_en;
  assign cif.wr_sel       = wr_sel;
  assign cif.wr_data      = wr_data;
  assign cif.period_match = period_match;
  assign cif.buf_en       = buffer_enable;

  compare_bank u_bank (
    .clk_sys (clk_sys),
    .reset   (reset),
    .cif     (cif.bank)
  );

  assign period_cmp  = cif.cmp[pwm_pkg::IDX_PERIOD];
  assign a_set_cmp   = cif.cmp[pwm_pkg::IDX_A_SET];
  assign b_clear_cmp = cif.cmp[pwm_pkg::IDX_B_CLEAR];
  assign b_set_cmp   = cif.cmp[pwm_pkg::IDX_B_SET];

  // =====================================================================
  // counter control
  // =====================================================================
  // a halt after period match is released only by dropping the run bit
  assign running      = count_run_bit && !st_q.halted;
  assign period_match = running && (st_q.count == period_cmp);
  // cutoff only acts while enabled; otherwise the pin is untouched
  assign cut          = cutoff_enable && cutoff_in;

  // =====================================================================
  // next state
  // =====================================================================
  always_comb begin
    st_d = st_q;

    if (running) begin
      if (period_match) begin
        st_d.count = pwm_pkg::COUNT_RESET;
      end else begin
        st_d.count = st_q.count + pwm_pkg::COUNT_STEP;
      end
    end

    if (!count_run_bit) begin
      st_d.halted = 1'b0;
    end else if (period_match && !match_continue_select) begin
      st_d.halted = 1'b1;
    end else begin
      st_d.halted = st_q.halted;
    end

    st_d.started = st_q.started || running;

    // windows are judged on the current count, so the pins lag it by one cycle
    st_d.act_a = st_q.started && (st_q.count > a_set_cmp) && (st_q.count <= period_cmp);
    st_d.act_b = st_q.started && (st_q.count > b_set_cmp) && (st_q.count <= b_clear_cmp);

    // cutoff drives the inactive level rather than releasing the pin
    st_d.pin_a  = (st_d.act_a && !cut) ~^ active_high_a;
    st_d.pin_b  = (st_d.act_b && !cut) ~^ active_high_b;
    st_d.oe_a_n = pin_enable_a ? pwm_pkg::OE_N_ON : pwm_pkg::OE_N_OFF;
    st_d.oe_b_n = pin_enable_b ? pwm_pkg::OE_N_ON : pwm_pkg::OE_N_OFF;

    // a match in the clearing cycle is kept
    st_d.flag = period_match || (st_q.flag && !flag_clear);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q.count   <= pwm_pkg::COUNT_RESET;
      st_q.halted  <= 1'b0;
      st_q.started <= 1'b0;
      st_q.act_a   <= 1'b0;
      st_q.act_b   <= 1'b0;
      st_q.pin_a   <= pwm_pkg::LEVEL_LOW;
      st_q.pin_b   <= pwm_pkg::LEVEL_LOW;
      st_q.oe_a_n  <= pwm_pkg::OE_N_OFF;
      st_q.oe_b_n  <= pwm_pkg::OE_N_OFF;
      st_q.flag    <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  assign count_register     = st_q.count;
  assign period_match_flag  = st_q.flag;
  assign period_irq         = st_q.flag && irq_enable;
  assign pwm_out_a          = st_q.pin_a;
  assign pwm_out_a_oe_n     = st_q.oe_a_n;
  assign pwm_out_b          = st_q.pin_b;
  assign pwm_out_b_oe_n     = st_q.oe_b_n;

  // the remaining six pins never drive in this mode
  assign unused_out_c0      = pwm_pkg::LEVEL_LOW;
  assign unused_out_c0_oe_n = pwm_pkg::OE_N_OFF;
  assign unused_out_d0      = pwm_pkg::LEVEL_LOW;
  assign unused_out_d0_oe_n = pwm_pkg::OE_N_OFF;
  assign unused_out_a1      = pwm_pkg::LEVEL_LOW;
  assign unused_out_a1_oe_n = pwm_pkg::OE_N_OFF;
  assign unused_out_b1      = pwm_pkg::LEVEL_LOW;
  assign unused_out_b1_oe_n = pwm_pkg::OE_N_OFF;
  assign unused_out_c1      = pwm_pkg::LEVEL_LOW;
  assign unused_out_c1_oe_n = pwm_pkg::OE_N_OFF;
  assign unused_out_d1      = pwm_pkg::LEVEL_LOW;
  assign unused_out_d1_oe_n = pwm_pkg::OE_N_OFF;

  // =====================================================================
  // checks
  // =====================================================================
  chk_count_step: assert property (@(posedge clk_sys) disable iff (reset)
    (running && !period_match) |=> (count_register == $past(count_register) + pwm_pkg::COUNT_STEP))
    else $error("counter did not step by one while running");

  chk_period_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    period_match |=> (count_register == pwm_pkg::COUNT_RESET))
    else $error("counter not cleared after period match");

  chk_continue_run: assert property (@(posedge clk_sys) disable iff (reset)
    (period_match && match_continue_select && count_run_bit) ##1 (count_run_bit && !period_match)
      |=> (count_register == pwm_pkg::COUNT_STEP))
    else $error("counter did not continue after period match");

  chk_period_len: assert property (@(posedge clk_sys) disable iff (reset)
    (running && count_register == pwm_pkg::COUNT_RESET && period_cmp == pwm_pkg::COUNT_STEP
      && match_continue_select && $stable(period_cmp))
      ##1 (running && period_match) |=> (count_register == pwm_pkg::COUNT_RESET))
    else $error("period of two cycles not kept for period value one");

  chk_stop_halt: assert property (@(posedge clk_sys) disable iff (reset)
    (period_match && !match_continue_select) |=> (count_register == pwm_pkg::COUNT_RESET) [*2])
    else $error("counter did not halt at period match");

  chk_run_stop: assert property (@(posedge clk_sys) disable iff (reset)
    !count_run_bit |=> $stable(count_register))
    else $error("counter moved with run bit low");

  chk_a_active: assert property (@(posedge clk_sys) disable iff (reset)
    (st_q.started && count_register == a_set_cmp + pwm_pkg::COUNT_STEP && count_register <= period_cmp
      && a_set_cmp != pwm_pkg::CMP_RESET)
      |=> st_q.act_a)
    else $error("output a not active after a_set plus one");

  chk_a_inactive: assert property (@(posedge clk_sys) disable iff (reset)
    (count_register <= a_set_cmp) |=> !st_q.act_a)
    else $error("output a active before a_set reached");

  chk_b_window: assert property (@(posedge clk_sys) disable iff (reset)
    (count_register <= b_set_cmp || count_register > b_clear_cmp) |=> !st_q.act_b)
    else $error("output b active outside its window");

  chk_init_low: assert property (@(posedge clk_sys) disable iff (reset)
    (!st_q.started && active_high_a && active_high_b && $past(active_high_a) && $past(active_high_b))
      |-> (pwm_out_a == pwm_pkg::LEVEL_LOW && pwm_out_b == pwm_pkg::LEVEL_LOW))
    else $error("outputs not low before counting began");

  chk_unused_off: assert property (@(posedge clk_sys) disable iff (reset)
    (unused_out_c0_oe_n && unused_out_d0_oe_n && unused_out_a1_oe_n
      && unused_out_b1_oe_n && unused_out_c1_oe_n && unused_out_d1_oe_n))
    else $error("an unused pin is enabled");

  chk_pin_enable: assert property (@(posedge clk_sys) disable iff (reset)
    !pin_enable_a |=> (pwm_out_a_oe_n == pwm_pkg::OE_N_OFF))
    else $error("output a enabled against its enable bit");

  chk_cutoff_ignored: assert property (@(posedge clk_sys) disable iff (reset)
    (!cutoff_enable && active_high_a) |=> (pwm_out_a == st_q.act_a))
    else $error("disabled cutoff changed output a");

  chk_irq_flag: assert property (@(posedge clk_sys) disable iff (reset)
    (period_match && irq_enable) |=> (period_match_flag && (period_irq || !irq_enable)))
    else $error("period match raised no interrupt");

  chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    (period_match_flag && !flag_clear) |=> period_match_flag)
    else $error("period flag dropped without a clear");

  chk_b_active: assert property (@(posedge clk_sys) disable iff (reset)
    (st_q.started && count_register == b_set_cmp + pwm_pkg::COUNT_STEP
      && count_register <= b_clear_cmp && b_set_cmp != pwm_pkg::CMP_RESET) |=> st_q.act_b)
    else $error("output b not active after b_set plus one");

  chk_pin_drive: assert property (@(posedge clk_sys) disable iff (reset)
    (pin_enable_a && pin_enable_b)
      |=> (pwm_out_a_oe_n == pwm_pkg::OE_N_ON && pwm_out_b_oe_n == pwm_pkg::OE_N_ON))
    else $error("an enabled output pin is not driven");

  chk_pin_enable_b: assert property (@(posedge clk_sys) disable iff (reset)
    !pin_enable_b
      |=> (pwm_out_b_oe_n == pwm_pkg::OE_N_OFF))
    else $error("output b enabled against its enable bit");

  chk_cutoff_forced: assert property (@(posedge clk_sys) disable iff (reset)
    cut
      |=> (pwm_out_a == !$past(active_high_a) && pwm_out_b == !$past(active_high_b)))
    else $error("cutoff did not force the inactive level");

  chk_active_low: assert property (@(posedge clk_sys) disable iff (reset)
    (!active_high_a && !cut)
      |=> (pwm_out_a == !st_q.act_a))
    else $error("active low output a not inverted");

  chk_irq_masked: assert property (@(posedge clk_sys) disable iff (reset)
    !irq_enable
      |-> !period_irq)
    else $error("interrupt raised while disabled");

  chk_set_wins: assert property (@(posedge clk_sys) disable iff (reset)
    (period_match && flag_clear)
      |=> period_match_flag)
    else $error("flag clear beat a coincident period match");

  chk_flag_clear: assert property (@(posedge clk_sys) disable iff (reset)
    (flag_clear && !period_match)
      |=> !period_match_flag)
    else $error("period flag not cleared");

  chk_halt_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (st_q.halted && count_run_bit)
      |=> $stable(count_register))
    else $error("halted counter moved while run bit high");

endmodule // dual_output_pwm_timer

//--- common/pwm_pkg.sv
// Purpose: shared constants and types for the dual output pwm timer
// Assumes: one 16-bit counter on clk_sys, four compare registers with buffers
// Notes:   select codes address compare registers first, buffers after them

package pwm_pkg;

  // =====================================================================
  // widths
  // =====================================================================
  localparam int CNT_W       = 16;
  localparam int NUM_CMP     = 4;
  localparam int SEL_W       = 3;

  typedef logic [CNT_W-1:0] count_t;
  typedef logic [SEL_W-1:0] reg_sel_t;
  typedef logic [NUM_CMP-1:0][CNT_W-1:0] cmp_bank_t;

  // =====================================================================
  // compare register indices and write select codes
  // =====================================================================
  localparam int IDX_PERIOD   = 0;
  localparam int IDX_B_CLEAR  = 1;
  localparam int IDX_A_SET    = 2;
  localparam int IDX_B_SET    = 3;
  // buffer of compare index i is selected by BUF_SEL_BASE + i
  localparam int BUF_SEL_BASE = 4;

  // =====================================================================
  // reset values and constants
  // =====================================================================
  localparam count_t COUNT_RESET  = 16'h0000;
  localparam count_t COUNT_STEP   = 16'h0001;
  localparam count_t CMP_RESET    = 16'hFFFF;
  localparam logic   LEVEL_LOW    = 1'b0;
  localparam logic   OE_N_OFF     = 1'b1;
  localparam logic   OE_N_ON      = 1'b0;

endpackage

//--- common/cmp_if.sv
// Purpose: carries compare register writes and values between core and bank
// Assumes: all signals synchronous to clk_sys
// Notes:   cmp comes straight from the bank flip-flops
`timescale 1ns/1ns

interface cmp_if;
  logic                       wr_en;
  pwm_pkg::reg_sel_t          wr_sel;
  pwm_pkg::count_t            wr_data;
  logic                       period_match;
  logic [pwm_pkg::NUM_CMP-1:0] buf_en;
  pwm_pkg::cmp_bank_t         cmp;

  modport bank (input wr_en, input wr_sel, input wr_data, input period_match, input buf_en, output cmp);
  modport core (output wr_en, output wr_sel, output wr_data, output period_match, output buf_en, input cmp);
endinterface

//--- hdl/compare_bank.sv
// Purpose: four compare registers, each with an optional buffer register
// Assumes: writes come one at a time; period_match is a one-cycle pulse
// Notes:   a direct compare write wins over a buffer load in the same cycle
`timescale 1ns/1ns

module compare_bank (
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   reset,
  // register traffic
  cmp_if.bank         cif
);

  // =====================================================================
  // state
  // =====================================================================
  typedef struct packed {
    pwm_pkg::cmp_bank_t cmp;
    pwm_pkg::cmp_bank_t buffer;
  } bank_s;

  bank_s              st_q;
  bank_s              st_d;
  pwm_pkg::cmp_bank_t cmp_nx;
  pwm_pkg::cmp_bank_t buf_nx;

  // =====================================================================
  // per-entry next values
  // =====================================================================
  for (genvar i = 0; i < pwm_pkg::NUM_CMP; i++) begin : g_entry
    localparam pwm_pkg::reg_sel_t CMP_SEL = pwm_pkg::reg_sel_t'(i);
    localparam pwm_pkg::reg_sel_t BUF_SEL = pwm_pkg::reg_sel_t'(i + pwm_pkg::BUF_SEL_BASE);
    logic hit_cmp;
    logic hit_buf;
    assign hit_cmp = cif.wr_en && (cif.wr_sel == CMP_SEL);
    assign hit_buf = cif.wr_en && (cif.wr_sel == BUF_SEL);
    // a buffered duty value reaches the compare at a period match; a direct write lands at once
    assign cmp_nx[i] = hit_cmp ? cif.wr_data :
                       (cif.period_match && cif.buf_en[i]) ? st_q.buffer[i] : st_q.cmp[i];
    assign buf_nx[i] = hit_buf ? cif.wr_data : st_q.buffer[i];
  end

  always_comb begin
    st_d        = st_q;
    st_d.cmp    = cmp_nx;
    st_d.buffer = buf_nx;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= {pwm_pkg::NUM_CMP * 2{pwm_pkg::CMP_RESET}};
    end else begin
      st_q <= st_d;
    end
  end

  assign cif.cmp = st_q.cmp;

  // =====================================================================
  // checks
  // =====================================================================
  chk_buffer_load: assert property (@(posedge clk_sys) disable iff (reset)
    (cif.period_match && cif.buf_en[pwm_pkg::IDX_A_SET] && !cif.wr_en)
      |=> (cif.cmp[pwm_pkg::IDX_A_SET] == $past(st_q.buffer[pwm_pkg::IDX_A_SET])))
    else $error("a_set compare did not load from its buffer at period match");

  chk_buffer_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (!cif.period_match && !cif.wr_en) |=> $stable(cif.cmp))
    else $error("compare changed with no write and no period match");

endmodule // compare_bank

//--- dv/pwm_load_model.sv
// Purpose: external loads hanging on the two driven pwm pins
// Assumes: each load line has a pull-down resistor
// Notes:   a released pin reads as the pull-down level, never its last value
`timescale 1ns/1ns

module pwm_load_model (
  // pins from the timer
  input  wire logic pin_a,
  input  wire logic pin_a_oe_n,
  input  wire logic pin_b,
  input  wire logic pin_b_oe_n,
  // levels seen by the loads
  output logic      line_a,
  output logic      line_b
);
  // =====================================================================
  // line resolution
  // =====================================================================
  assign line_a = pin_a_oe_n ? 1'b0 : pin_a;
  assign line_b = pin_b_oe_n ? 1'b0 : pin_b;
endmodule // pwm_load_model

//--- dv/dual_output_pwm_timer_test.sv
// Purpose: self-checking bench for the dual output pwm timer
// Assumes: inputs change 5 ns after the rising edge; outputs checked 2 ns after it
// Notes:   a cycle model of counter, compares and pins predicts every output
`timescale 1ns/1ns

module dual_output_pwm_timer_test;
  logic clk_sys, reset, count_run_bit, match_continue_select, wr_en;
  logic [pwm_pkg::NUM_CMP-1:0] buffer_enable;
  pwm_pkg::reg_sel_t wr_sel;
  pwm_pkg::count_t   wr_data, count_register, exp_cnt;
  logic pin_enable_a, pin_enable_b, active_high_a, active_high_b, cutoff_enable, cutoff_in;
  logic irq_enable, flag_clear, period_match_flag, period_irq;
  logic pwm_out_a, pwm_out_a_oe_n, pwm_out_b, pwm_out_b_oe_n, line_a, line_b;
  logic [11:0] unused_pins;
  pwm_pkg::count_t exp_cmp [4];
  pwm_pkg::count_t exp_buf [4];
  logic exp_halt, exp_flag, exp_pa, exp_pb, exp_oea, exp_oeb, model_ok, run, match, cut, isr_on;
  int bad_count, check_count, cycles;
  int unsigned seed_val;

  dual_output_pwm_timer u_dut (
    .clk_sys(clk_sys), .reset(reset), .count_run_bit(count_run_bit),
    .match_continue_select(match_continue_select), .buffer_enable(buffer_enable),
    .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
    .pin_enable_a(pin_enable_a), .pin_enable_b(pin_enable_b),
    .active_high_a(active_high_a), .active_high_b(active_high_b),
    .cutoff_enable(cutoff_enable), .cutoff_in(cutoff_in), .irq_enable(irq_enable),
    .flag_clear(flag_clear), .period_match_flag(period_match_flag), .period_irq(period_irq),
    .count_register(count_register), .pwm_out_a(pwm_out_a), .pwm_out_a_oe_n(pwm_out_a_oe_n),
    .pwm_out_b(pwm_out_b), .pwm_out_b_oe_n(pwm_out_b_oe_n),
    .unused_out_c0(unused_pins[11]), .unused_out_c0_oe_n(unused_pins[10]),
    .unused_out_d0(unused_pins[9]), .unused_out_d0_oe_n(unused_pins[8]),
    .unused_out_a1(unused_pins[7]), .unused_out_a1_oe_n(unused_pins[6]),
    .unused_out_b1(unused_pins[5]), .unused_out_b1_oe_n(unused_pins[4]),
    .unused_out_c1(unused_pins[3]), .unused_out_c1_oe_n(unused_pins[2]),
    .unused_out_d1(unused_pins[1]), .unused_out_d1_oe_n(unused_pins[0]));

  pwm_load_model u_load (
    .pin_a(pwm_out_a), .pin_a_oe_n(pwm_out_a_oe_n), .pin_b(pwm_out_b),
    .pin_b_oe_n(pwm_out_b_oe_n), .line_a(line_a), .line_b(line_b));

  // =====================================================================
  // clock, timeout, verdict
  // =====================================================================
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 12000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  // pin level for a window (lo, hi] of the count, forced inactive by cutoff
  function automatic logic exp_pin(input pwm_pkg::count_t c, input pwm_pkg::count_t lo,
                                   input pwm_pkg::count_t hi, input logic cut_on, input logic act_hi);
    return ((c > lo) && (c <= hi) && !cut_on) ~^ act_hi;
  endfunction

  // =====================================================================
  // cycle model and per-cycle comparison
  // =====================================================================
  always @(posedge clk_sys) begin
    if (reset) begin
      exp_cnt = pwm_pkg::COUNT_RESET;
      {exp_halt, exp_flag, exp_pa, exp_pb, exp_oea, exp_oeb, model_ok} = 7'b0000111;
      for (int i = 0; i < 4; i++) begin
        exp_cmp[i] = pwm_pkg::CMP_RESET;
        exp_buf[i] = pwm_pkg::CMP_RESET;
      end
    end else begin
      run   = count_run_bit & ~exp_halt;
      match = run && (exp_cnt == exp_cmp[pwm_pkg::IDX_PERIOD]);
      cut   = cutoff_enable & cutoff_in;
      exp_pa = exp_pin(exp_cnt, exp_cmp[pwm_pkg::IDX_A_SET], exp_cmp[pwm_pkg::IDX_PERIOD], cut, active_high_a);
      exp_pb = exp_pin(exp_cnt, exp_cmp[pwm_pkg::IDX_B_SET], exp_cmp[pwm_pkg::IDX_B_CLEAR], cut, active_high_b);
      exp_oea = ~pin_enable_a;
      exp_oeb = ~pin_enable_b;
      exp_flag = match | (exp_flag & ~flag_clear);
      for (int i = 0; i < 4; i++) begin
        if (match && buffer_enable[i]) exp_cmp[i] = exp_buf[i];
      end
      if (wr_en && !wr_sel[2]) exp_cmp[wr_sel[1:0]] = wr_data;
      if (wr_en && wr_sel[2]) exp_buf[wr_sel[1:0]] = wr_data;
      if (!count_run_bit) exp_halt = 1'b0;
      else if (match && !match_continue_select) exp_halt = 1'b1;
      if (run) exp_cnt = match ? pwm_pkg::COUNT_RESET : exp_cnt + pwm_pkg::COUNT_STEP;
    end
    #2;
    if (model_ok) begin
      check_word("count_register", exp_cnt, count_register);
      check_bit("pwm_out_a", exp_pa, pwm_out_a);
      check_bit("pwm_out_b", exp_pb, pwm_out_b);
      check_bit("pwm_out_a_oe_n", exp_oea, pwm_out_a_oe_n);
      check_bit("pwm_out_b_oe_n", exp_oeb, pwm_out_b_oe_n);
      check_word("unused_pins", 16'h0555, {4'h0, unused_pins});
      check_bit("line_a", exp_oea ? 1'b0 : exp_pa, line_a);
      check_bit("line_b", exp_oeb ? 1'b0 : exp_pb, line_b);
      check_bit("period_match_flag", exp_flag, period_match_flag);
      check_bit("period_irq", exp_flag & irq_enable, period_irq);
    end
  end

  // service routine: clears the flag once it is seen, so the next match shows again
  always @(posedge clk_sys) begin
    #5;
    flag_clear = isr_on & period_match_flag & ~reset;
  end

  // =====================================================================
  // stimulus
  // =====================================================================
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask

  // base 0 writes the compares, base 4 the buffers; order period, b_clear, a_set, b_set
  task automatic write_bank(input int base, input pwm_pkg::cmp_bank_t v);
    for (int i = 0; i < 4; i++) begin
      wr_en   = 1'b1;
      wr_sel  = pwm_pkg::reg_sel_t'(base + i);
      wr_data = v[i];
      tick(1);
    end
    wr_en = 1'b0;
    // let an edge pass so a following call never re-raises wr_en in the same step
    tick(1);
  endtask

  initial begin
    {count_run_bit, match_continue_select, wr_en, pin_enable_a, pin_enable_b} = 5'b00000;
    {active_high_a, active_high_b, cutoff_enable, cutoff_in, irq_enable, isr_on} = 6'b110000;
    {buffer_enable, wr_sel, wr_data, flag_clear, model_ok, cycles} = '0;
    {bad_count, check_count} = '0;
    reset = 1'b1;
    seed_val = $urandom(32'hb32b);
    tick(20);
    reset = 1'b0;
    {pin_enable_a, pin_enable_b, match_continue_select, irq_enable} = 4'b1111;
    write_bank(0, {16'h0002, 16'h0005, 16'h0006, 16'h0009});
    write_bank(4, {16'h0000, 16'h0000, 16'h0004, 16'h0004});
    buffer_enable = 4'hF;
    count_run_bit = 1'b1;
    tick(25);
    cutoff_in = 1'b1;
    isr_on    = 1'b1;
    write_bank(4, {16'h0003, 16'h0007, 16'h0008, 16'h000B});
    tick(20);
    cutoff_enable = 1'b1;
    {active_high_a, match_continue_select} = 2'b00;
    tick(30);
    count_run_bit = 1'b0;
    tick(3);
    {count_run_bit, match_continue_select, cutoff_enable, active_high_a} = 4'b1101;
    tick(15);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    count_run_bit = 1'b1;
    tick(10);
    for (int k = 0; k < 300; k++) begin
      count_run_bit         = ($urandom % 8) != 0;
      match_continue_select = ($urandom % 6) != 0;
      buffer_enable         = 4'($urandom);
      {cutoff_enable, cutoff_in, irq_enable, isr_on} = 4'($urandom);
      pin_enable_a          = ($urandom % 5) != 0;
      pin_enable_b          = ($urandom % 5) != 0;
      active_high_a         = ($urandom % 4) != 0;
      active_high_b         = ($urandom % 4) != 0;
      wr_en                 = ($urandom % 2) == 1;
      wr_sel                = pwm_pkg::reg_sel_t'($urandom);
      wr_data               = pwm_pkg::count_t'($urandom % 24);
      tick(1);
      wr_en = 1'b0;
      tick(1 + $urandom % 12);
    end
    print_verdict();
  end
endmodule // dual_output_pwm_timer_test
